// ### rtl/pdi_bridge.sv
`default_nettype none
module pdi_bridge
  import pdi_pkg::*;
#(
  parameter int RST_HOLD = RST_HOLD_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_vma,
  input wire logic i_rw,
  input wire logic [7:0] i_wdata,
  input wire logic i_diag_jumper,
  input wire logic i_service_request_line_n,
  input wire logic [7:0] i_port_a_lines,
  input wire logic [7:0] i_port_b_lines,
  output logic o_phi2,
  output logic o_cpu_rst_n,
  output logic o_irq_n,
  output logic o_nmi_n,
  output logic [15:0] o_bus_addr,
  output logic o_data_buf_en,
  output logic o_data_buf_to_cpu,
  output logic [7:0] o_rdata,
  output logic o_sel_main_ram,
  output logic o_sel_if_ram,
  output logic o_sel_inst_bus,
  output logic o_sel_gpia,
  output logic o_sel_switch,
  output logic [DIAG_W-1:0] o_diag_led,
  output logic [7:0] o_port_a_lines,
  output logic [7:0] o_port_a_oe,
  output logic [7:0] o_port_b_lines,
  output logic [7:0] o_port_b_oe,
  output logic o_aux_output_a,
  output logic o_aux_output_b,
  output logic o_inst_read_dir
);

  // ----------------------------------------
  // second-phase enable divider
  // ----------------------------------------
  // one core clock only: the phase is a level out and a pulse inside
  logic [PHI_CNT_W-1:0] phi_cnt;
  logic phi2_en;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      phi_cnt <= '0;
      o_phi2 <= 1'b0;
      phi2_en <= 1'b0;
    end else begin
      phi2_en <= 1'b0;
      if (phi_cnt == PHI_CNT_W'(PHI_DIV - 1)) begin
        phi_cnt <= '0;
        o_phi2 <= 1'b0;
        phi2_en <= 1'b1;
      end else begin
        phi_cnt <= phi_cnt + PHI_CNT_W'(1);
        if (phi_cnt == PHI_CNT_W'(PHI_DIV / 2)) begin
          o_phi2 <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // power-up reset timer
  // ----------------------------------------
  // the processor then fetches its start vector from the two top addresses
  // counter stops once released, so it cannot wrap back into reset
  logic [RST_CNT_W-1:0] rst_cnt;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rst_cnt <= '0;
      o_cpu_rst_n <= 1'b0;
    end else if (rst_cnt == RST_CNT_W'(RST_HOLD - 1)) begin
      o_cpu_rst_n <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + RST_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // interrupt lines
  // ----------------------------------------
  // request bypasses the adapter; masking is the firmware's, so no gate here
  // one flop only: the request is already synchronous to the core clock
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_irq_n <= 1'b1;
      o_nmi_n <= 1'b1;
    end else begin
      o_irq_n <= i_service_request_line_n;
      o_nmi_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // address decoders
  // ----------------------------------------
  logic pri_en;
  logic [2:0] pri_code;
  logic sec_en;
  logic [1:0] sec_code;
  always_comb begin
    pri_en = i_vma && !i_addr[A_TOP_MSB] && !i_addr[A_TOP_LSB];
    pri_code = i_addr[A_PRI_MSB:A_PRI_LSB];
    sec_en = pri_en && (pri_code == PRI_IO);
    sec_code = i_addr[A_SEC_MSB:A_SEC_LSB];
  end

  // selects lag the address by one core clock
  // rom ranges get no select here, their boards decode them
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_sel_main_ram <= 1'b0;
      o_sel_if_ram <= 1'b0;
      o_sel_inst_bus <= 1'b0;
      o_sel_gpia <= 1'b0;
      o_sel_switch <= 1'b0;
    end else begin
      o_sel_main_ram <= pri_en && (pri_code == PRI_MAIN_RAM);
      o_sel_if_ram <= pri_en && (pri_code == PRI_IF_RAM);
      o_sel_inst_bus <= sec_en && (sec_code == SEC_INST_BUS);
      o_sel_gpia <= sec_en && (sec_code == SEC_GPIA);
      o_sel_switch <= sec_en && (sec_code == SEC_SWITCH);
    end
  end

  // ----------------------------------------
  // diagnostic indicators
  // ----------------------------------------
  // lit by any access to an otherwise idle decode output; held until reset
  // codes six and seven stay unused; rom codes three to five light lamps
  // limitation: normal running from those rom blocks lights them as well
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_diag_led <= '0;
    end else if (phi2_en) begin
      if (sec_en && (sec_code == SEC_UNUSED)) begin
        o_diag_led[0] <= 1'b1;
      end
      if (pri_en && (pri_code == PRI_ROM_FIRST)) begin
        o_diag_led[1] <= 1'b1;
      end
      if (pri_en && (pri_code == PRI_LAMP_MID)) begin
        o_diag_led[2] <= 1'b1;
      end
      if (pri_en && (pri_code == PRI_LAMP_END)) begin
        o_diag_led[3] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // processor bus buffers
  // ----------------------------------------
  // jumper low isolates the processor data lines for diagnostics
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_bus_addr <= '0;
      o_data_buf_en <= 1'b0;
      o_data_buf_to_cpu <= 1'b1;
    end else begin
      o_bus_addr <= i_addr;
      o_data_buf_en <= i_diag_jumper;
      o_data_buf_to_cpu <= i_rw;
    end
  end

  // ----------------------------------------
  // adapter select and access strobes
  // ----------------------------------------
  // select lines zero and one are tied on, so only the bus decode matters
  // the whole 1000-11FF block reaches the adapter; only the lsbs pick a register
  logic adapter_select;
  logic [1:0] reg_sel;
  logic wr_stb;
  logic rd_stb;
  always_comb begin
    adapter_select = sec_en && (sec_code == SEC_INST_BUS);
    reg_sel = i_addr[1:0];
    wr_stb = phi2_en && adapter_select && !i_rw;
    rd_stb = phi2_en && adapter_select && i_rw;
  end

  // ----------------------------------------
  // adapter registers
  // ----------------------------------------
  logic [7:0] port_a_data;
  logic [7:0] port_a_direction;
  logic [7:0] port_a_control;
  logic [7:0] port_b_data;
  logic [7:0] port_b_direction;
  logic [7:0] port_b_control;
  logic port_a_select_bit;
  logic port_b_select_bit;
  assign port_a_select_bit = port_a_control[CR_SEL_BIT];
  assign port_b_select_bit = port_b_control[CR_SEL_BIT];

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      port_a_data <= BYTE_ZERO;
      port_a_direction <= BYTE_ZERO;
      port_a_control <= BYTE_ZERO;
    end else if (wr_stb) begin
      if (reg_sel == RS_PORT_A) begin
        if (port_a_select_bit) begin
          port_a_data <= i_wdata;
        end else begin
          port_a_direction <= i_wdata;
        end
      end else if (reg_sel == RS_CTRL_A) begin
        port_a_control <= {2'b00, i_wdata[CR_WR_MSB:0]};
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      port_b_data <= BYTE_ZERO;
      port_b_direction <= BYTE_ZERO;
      port_b_control <= BYTE_ZERO;
    end else if (wr_stb) begin
      if (reg_sel == RS_PORT_B) begin
        if (port_b_select_bit) begin
          port_b_data <= i_wdata;
        end else begin
          port_b_direction <= i_wdata;
        end
      end else if (reg_sel == RS_CTRL_B) begin
        port_b_control <= {2'b00, i_wdata[CR_WR_MSB:0]};
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // input lines read the pin, output lines read back the stored bit
  logic [7:0] port_a_view;
  logic [7:0] port_b_view;
  logic [7:0] next_rdata;
  always_comb begin
    port_a_view = (port_a_data & port_a_direction) | (i_port_a_lines & ~port_a_direction);
    port_b_view = (port_b_data & port_b_direction) | (i_port_b_lines & ~port_b_direction);
    next_rdata = BYTE_ZERO;
    if (reg_sel == RS_PORT_A) begin
      next_rdata = port_a_select_bit ? port_a_view : port_a_direction;
    end else if (reg_sel == RS_CTRL_A) begin
      next_rdata = port_a_control;
    end else if (reg_sel == RS_PORT_B) begin
      next_rdata = port_b_select_bit ? port_b_view : port_b_direction;
    end else begin
      next_rdata = port_b_control;
    end
  end

  // unselected reads show all ones, as the floating bus would
  // reads have no side effect on the registers, so polling is harmless
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= BYTE_ONES;
    end else if (adapter_select && i_rw) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= BYTE_ONES;
    end
  end

  // ----------------------------------------
  // port pins
  // ----------------------------------------
  // pins follow the registers one clock late, never mid-write
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_port_a_lines <= BYTE_ZERO;
      o_port_a_oe <= BYTE_ZERO;
      o_port_b_lines <= BYTE_ZERO;
      o_port_b_oe <= BYTE_ZERO;
      o_inst_read_dir <= 1'b0;
    end else begin
      o_port_a_lines <= port_a_data;
      o_port_a_oe <= port_a_direction;
      o_port_b_lines <= port_b_data;
      o_port_b_oe <= port_b_direction;
      o_inst_read_dir <= port_a_data[INST_ADDR_MSB];
    end
  end

  // ----------------------------------------
  // auxiliary outputs
  // ----------------------------------------
  // bit 5 low: not an output, line idles high
  // bits 5,4 high: level follows bit 3
  // bit 5 high, bit 4 low: active-low pulse for one processor cycle after a port A data read or a port B data read or write;
  // no handshake input exists here, so both pulse codes share one behaviour
  logic port_a_access;
  logic port_b_access;
  logic pulse_a;
  logic pulse_b;
  assign port_a_access = rd_stb && (reg_sel == RS_PORT_A) && port_a_select_bit;
  assign port_b_access = (rd_stb || wr_stb) && (reg_sel == RS_PORT_B) && port_b_select_bit;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pulse_a <= 1'b0;
      pulse_b <= 1'b0;
    end else begin
      if (port_a_access) begin
        pulse_a <= 1'b1;
      end else if (phi2_en) begin
        pulse_a <= 1'b0;
      end
      if (port_b_access) begin
        pulse_b <= 1'b1;
      end else if (phi2_en) begin
        pulse_b <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_aux_output_a <= 1'b1;
      o_aux_output_b <= 1'b1;
    end else begin
      if (!port_a_control[CR_AUX_OUT]) begin
        o_aux_output_a <= 1'b1;
      end else if (port_a_control[CR_AUX_MAN]) begin
        o_aux_output_a <= port_a_control[CR_AUX_LVL];
      end else begin
        o_aux_output_a <= !pulse_a;
      end
      if (!port_b_control[CR_AUX_OUT]) begin
        o_aux_output_b <= 1'b1;
      end else if (port_b_control[CR_AUX_MAN]) begin
        o_aux_output_b <= port_b_control[CR_AUX_LVL];
      end else begin
        o_aux_output_b <= !pulse_b;
      end
    end
  end

endmodule // pdi_bridge
`default_nettype wire

// ### rtl/pdi_pkg.sv
`default_nettype none
package pdi_pkg;
  // ----------------------------------------
  // clocks and timing
  // ----------------------------------------
  localparam int CORE_CLK_KHZ = 125000;
  localparam int CPU_CLK_KHZ = 850;
  localparam int PHI_DIV = CORE_CLK_KHZ / CPU_CLK_KHZ;
  localparam int PHI_CNT_W = 8;
  localparam int RST_HOLD_MS = 1000;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * (CORE_CLK_KHZ);
  localparam int RST_CNT_W = 27;
  // ----------------------------------------
  // processor address map
  // ----------------------------------------
  localparam logic [15:0] VEC_RESET_HI = 16'hFFFE;
  localparam logic [15:0] VEC_RESET_LO = 16'hFFFF;
  localparam int A_TOP_MSB = 15;
  localparam int A_TOP_LSB = 14;
  localparam int A_PRI_MSB = 13;
  localparam int A_PRI_LSB = 11;
  localparam int A_SEC_MSB = 10;
  localparam int A_SEC_LSB = 9;
  localparam logic [2:0] PRI_MAIN_RAM = 3'h0;
  localparam logic [2:0] PRI_IF_RAM = 3'h1;
  localparam logic [2:0] PRI_IO = 3'h2;
  localparam logic [2:0] PRI_ROM_FIRST = 3'h3;
  localparam logic [2:0] PRI_ROM_LAST = 3'h6;
  localparam logic [2:0] PRI_LAMP_MID = 3'h4;
  localparam logic [2:0] PRI_LAMP_END = 3'h5;
  localparam logic [1:0] SEC_INST_BUS = 2'h0;
  localparam logic [1:0] SEC_GPIA = 2'h1;
  localparam logic [1:0] SEC_SWITCH = 2'h2;
  localparam logic [1:0] SEC_UNUSED = 2'h3;
  localparam int DIAG_W = 4;
  // ----------------------------------------
  // adapter register selects and control fields
  // ----------------------------------------
  localparam logic [1:0] RS_PORT_A = 2'h0;
  localparam logic [1:0] RS_CTRL_A = 2'h1;
  localparam logic [1:0] RS_PORT_B = 2'h2;
  localparam logic [1:0] RS_CTRL_B = 2'h3;
  localparam int CR_SEL_BIT = 2;
  localparam int CR_AUX_LVL = 3;
  localparam int CR_AUX_MAN = 4;
  localparam int CR_AUX_OUT = 5;
  localparam int CR_WR_MSB = 5;
  localparam int INST_ADDR_MSB = 7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
endpackage
`default_nettype wire

// ### tb/pdi_bridge_checker.sv
`default_nettype none
module pdi_bridge_checker
  import pdi_pkg::*;
#(
  parameter int RST_HOLD = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic i_vma,
  input wire logic i_diag_jumper,
  input wire logic i_service_request_line_n,
  input wire logic o_cpu_rst_n,
  input wire logic o_irq_n,
  input wire logic o_nmi_n,
  input wire logic o_data_buf_en,
  input wire logic o_sel_main_ram,
  input wire logic o_sel_if_ram,
  input wire logic o_sel_inst_bus,
  input wire logic o_sel_gpia,
  input wire logic o_sel_switch,
  input wire logic [DIAG_W-1:0] o_diag_led
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // decode and pass-through checks
  // ----------------------------------------
  localparam int RH_MAX = RST_HOLD + 2;
  logic [4:0] sels;
  assign sels = {o_sel_main_ram, o_sel_if_ram, o_sel_inst_bus, o_sel_gpia, o_sel_switch};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_nmi;
    o_nmi_n;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi active");
  property p_off;
    (!i_vma || i_addr[15:14] != 2'h0) |=> sels == 5'h00;
  endproperty
  a_off: assert property (p_off) else $error("select outside range");
  property p_ram;
    (i_vma && i_addr[15:11] == 5'h00) |=> o_sel_main_ram;
  endproperty
  a_ram: assert property (p_ram) else $error("main ram not selected");
  property p_inst;
    (i_vma && i_addr[15:9] == 7'h08) |=> o_sel_inst_bus;
  endproperty
  a_inst: assert property (p_inst) else $error("port not selected");
  property p_hot;
    $onehot0(sels);
  endproperty
  a_hot: assert property (p_hot) else $error("several selects");
  property p_irq;
    1 |=> o_irq_n == $past(i_service_request_line_n);
  endproperty
  a_irq: assert property (p_irq) else $error("request not passed");
  property p_jmp;
    1 |=> o_data_buf_en == $past(i_diag_jumper);
  endproperty
  a_jmp: assert property (p_jmp) else $error("buffer enable wrong");
  // lamps only ever turn on until the next reset
  property p_led;
    1 |=> (o_diag_led & $past(o_diag_led)) == $past(o_diag_led);
  endproperty
  a_led: assert property (p_led) else $error("lamp cleared");
  property p_rst;
    $rose(i_rst_n) |-> !o_cpu_rst_n [*8] ##[1:RH_MAX] o_cpu_rst_n;
  endproperty
  a_rst: assert property (p_rst) else $error("cpu reset hold wrong");
  // cycles spent in processor reset since release, for the exact length
  int low_cnt;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      low_cnt <= 0;
    end else if (!o_cpu_rst_n) begin
      low_cnt <= low_cnt + 1;
    end
  end
  property p_rst_len;
    $rose(o_cpu_rst_n) |-> low_cnt == RST_HOLD;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("cpu reset length wrong");
endmodule // pdi_bridge_checker
bind pdi_bridge pdi_bridge_checker #(.RST_HOLD(RST_HOLD)) pdi_bridge_checker_i (.i_core_clk,
  .i_rst_n, .i_addr, .i_vma, .i_diag_jumper, .i_service_request_line_n, .o_cpu_rst_n,
  .o_irq_n, .o_nmi_n, .o_data_buf_en, .o_sel_main_ram, .o_sel_if_ram, .o_sel_inst_bus,
  .o_sel_gpia, .o_sel_switch, .o_diag_led);
`default_nettype wire

// ### tb/pdi_bridge_tb.sv
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module pdi_bridge_tb
  import pdi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  int err_count = 0;
  int compares = 0;
  logic i_core_clk, i_rst_n, i_vma, i_rw, i_diag_jumper, i_service_request_line_n;
  logic [15:0] i_addr, o_bus_addr;
  logic [7:0] i_wdata, i_port_a_lines, i_port_b_lines, o_rdata, rd;
  logic [7:0] o_port_a_lines, o_port_a_oe, o_port_b_lines, o_port_b_oe;
  logic o_phi2, o_cpu_rst_n, o_irq_n, o_nmi_n, o_data_buf_en, o_data_buf_to_cpu;
  logic o_sel_main_ram, o_sel_if_ram, o_sel_inst_bus, o_sel_gpia, o_sel_switch;
  logic o_aux_output_a, o_aux_output_b, o_inst_read_dir;
  logic [DIAG_W-1:0] o_diag_led;
  logic [4:0] sels;
  assign sels = {o_sel_main_ram, o_sel_if_ram, o_sel_inst_bus, o_sel_gpia, o_sel_switch};
  // ----------------------------------------
  // design, far side and pins
  // ----------------------------------------
  pdi_bridge #(.RST_HOLD(20)) pdi_bridge_i (.i_core_clk, .i_rst_n, .i_addr, .i_vma, .i_rw,
    .i_wdata, .i_diag_jumper, .i_service_request_line_n, .i_port_a_lines, .i_port_b_lines,
    .o_phi2, .o_cpu_rst_n, .o_irq_n, .o_nmi_n, .o_bus_addr, .o_data_buf_en,
    .o_data_buf_to_cpu, .o_rdata, .o_sel_main_ram, .o_sel_if_ram, .o_sel_inst_bus,
    .o_sel_gpia, .o_sel_switch, .o_diag_led, .o_port_a_lines, .o_port_a_oe, .o_port_b_lines,
    .o_port_b_oe, .o_aux_output_a, .o_aux_output_b, .o_inst_read_dir);
  pdi_inst_bus_model pdi_inst_bus_model_i (.i_addr_lines(i_port_a_lines),
    .i_data_out(o_port_b_lines), .i_data_oe(o_port_b_oe), .i_strobe_n(o_aux_output_b),
    .o_data_lines(i_port_b_lines));
  // undriven address pins float high
  assign i_port_a_lines = (o_port_a_lines & o_port_a_oe) | ~o_port_a_oe;
  initial begin
    i_core_clk = 1'h0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // held a processor cycle plus two, so at least one phi2 edge falls inside
  task automatic acc(input logic rw, input logic [1:0] rs, input logic [7:0] wd,
    output logic [7:0] q);
    i_addr = {14'h0400, rs};
    i_vma = 1'h1;
    i_rw = rw;
    i_wdata = wd;
    repeat (149) @(negedge i_core_clk);
    q = o_rdata;
    i_vma = 1'h0;
    i_rw = 1'h1;
    @(negedge i_core_clk);
  endtask
  task automatic t_reset();
    int k;
    int hi;
    `CHK("cpu_rst", 1'h0, o_cpu_rst_n)
    for (k = 0; k < 40 && o_cpu_rst_n !== 1'h1; k++) @(negedge i_core_clk);
    if (k == 40) begin
      err_count++;
      stop_test();
    end
    `CHK("nmi", 1'h1, o_nmi_n)
    hi = 0;
    repeat (PHI_DIV) begin
      @(negedge i_core_clk);
      hi += int'(o_phi2 === 1'h1);
    end
    `CHK("phi2_high", PHI_DIV - PHI_DIV / 2 - 1, hi)
    i_service_request_line_n = 1'h0;
    i_diag_jumper = 1'h0;
    i_addr = 16'hABCD;
    i_rw = 1'h0;
    repeat (2) @(negedge i_core_clk);
    `CHK("irq", 1'h0, o_irq_n)
    `CHK("buf_en", 1'h0, o_data_buf_en)
    `CHK("buf_dir", 1'h0, o_data_buf_to_cpu)
    `CHK("bus_addr", 16'hABCD, o_bus_addr)
    i_service_request_line_n = 1'h1;
    i_diag_jumper = 1'h1;
    i_rw = 1'h1;
    @(negedge i_core_clk);
    `CHK("irq_idle", 1'h1, o_irq_n)
    `CHK("buf_en_on", 1'h1, o_data_buf_en)
    `CHK("buf_dir_rd", 1'h1, o_data_buf_to_cpu)
    $display("t_reset done");
  endtask
  task automatic t_decode();
    logic [15:0] a [13] = '{16'h0000, 16'h0800, 16'h1000, 16'h1200, 16'h1400, 16'h1600,
      16'h1800, 16'h2000, 16'h2800, 16'h3000, 16'h3800, 16'h4000, 16'hC000};
    logic [4:0] e [13] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00,
      5'h00, 5'h00, 5'h00, 5'h00};
    foreach (a[k]) begin
      i_addr = a[k];
      i_vma = 1'h1;
      repeat (148) @(negedge i_core_clk);
      `CHK("selects", e[k], sels)
    end
    i_vma = 1'h0;
    i_addr = 16'h0000;
    repeat (2) @(negedge i_core_clk);
    `CHK("no_vma", 5'h00, sels)
    `CHK("lamps", 4'hF, o_diag_led)
    $display("t_decode done");
  endtask
  task automatic t_port_a();
    acc(1'h1, RS_CTRL_A, 8'h00, rd);
    `CHK("ctrl_a_rst", 8'h00, rd)
    acc(1'h1, RS_PORT_A, 8'h00, rd);
    `CHK("dir_a_rst", 8'h00, rd)
    acc(1'h0, RS_PORT_A, 8'hFF, rd);
    acc(1'h0, RS_CTRL_A, 8'hFC, rd);
    acc(1'h1, RS_CTRL_A, 8'h00, rd);
    `CHK("ctrl_a", 8'h3C, rd)
    `CHK("poll_on", 1'h1, o_aux_output_a)
    acc(1'h0, RS_CTRL_A, 8'h34, rd);
    `CHK("poll_off", 1'h0, o_aux_output_a)
    acc(1'h0, RS_PORT_A, 8'h85, rd);
    `CHK("addr_oe", 8'hFF, o_port_a_oe)
    `CHK("addr_lines", 8'h85, o_port_a_lines)
    `CHK("read_dir", 1'h1, o_inst_read_dir)
    acc(1'h1, RS_PORT_A, 8'h00, rd);
    `CHK("port_a", 8'h85, rd)
    acc(1'h0, RS_CTRL_A, 8'h24, rd);
    acc(1'h1, RS_PORT_A, 8'h00, rd);
    `CHK("port_a_again", 8'h85, rd)
    `CHK("poll_pulse", 1'h0, o_aux_output_a)
    repeat (150) @(negedge i_core_clk);
    `CHK("poll_idle", 1'h1, o_aux_output_a)
    $display("t_port_a done");
  endtask
  task automatic t_port_b();
    acc(1'h0, RS_PORT_B, 8'h0F, rd);
    acc(1'h0, RS_CTRL_B, 8'h24, rd);
    acc(1'h0, RS_PORT_A, 8'h01, rd);
    `CHK("write_dir", 1'h0, o_inst_read_dir)
    acc(1'h0, RS_PORT_B, 8'h35, rd);
    `CHK("strobe_low", 1'h0, o_aux_output_b)
    `CHK("data_oe", 8'h0F, o_port_b_oe)
    `CHK("data_lines", 8'h35, o_port_b_lines)
    repeat (150) @(negedge i_core_clk);
    `CHK("strobe_high", 1'h1, o_aux_output_b)
    `CHK("far_reg", 8'hF5, pdi_inst_bus_model_i.wreg)
    acc(1'h0, RS_PORT_A, 8'h83, rd);
    acc(1'h1, RS_PORT_B, 8'h00, rd);
    `CHK("status", 8'hA5, rd)
    acc(1'h0, RS_PORT_A, 8'h90, rd);
    acc(1'h1, RS_PORT_B, 8'h00, rd);
    `CHK("float", 8'hF5, rd)
    $display("t_port_b done");
  endtask
  initial begin
    i_rst_n = 1'h0;
    i_addr = 16'h0000;
    i_vma = 1'h0;
    i_rw = 1'h1;
    i_wdata = 8'h00;
    i_diag_jumper = 1'h1;
    i_service_request_line_n = 1'h1;
    repeat (5) @(negedge i_core_clk);
    i_rst_n = 1'h1;
    t_reset();
    t_decode();
    t_port_a();
    t_port_b();
    stop_test();
  end
endmodule // pdi_bridge_tb
`default_nettype wire

// ### tb/pdi_inst_bus_model.sv
`default_nettype none
module pdi_inst_bus_model #(
  parameter logic [7:0] STAT_ADDR = 8'h83,
  parameter logic [7:0] STAT_VAL = 8'hA6,
  parameter logic [7:0] WR_ADDR = 8'h01
) (
  input wire logic [7:0] i_addr_lines,
  input wire logic [7:0] i_data_out,
  input wire logic [7:0] i_data_oe,
  input wire logic i_strobe_n,
  output logic [7:0] o_data_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // one status register, one write register
  // ----------------------------------------
  logic [7:0] wreg = 8'h00;
  logic [7:0] drive;
  // buffer opens only while the strobe is low; otherwise pull-ups
  assign drive = (!i_strobe_n && i_addr_lines[7] && i_addr_lines == STAT_ADDR) ? STAT_VAL :
    8'hFF;
  assign o_data_lines = (i_data_out & i_data_oe) | (drive & ~i_data_oe);
  // latch on trailing edge, data has settled by then
  always @(posedge i_strobe_n) begin
    if (!i_addr_lines[7] && i_addr_lines == WR_ADDR) begin
      wreg <= o_data_lines;
    end
  end
endmodule // pdi_inst_bus_model
`default_nettype wire
